//--- inc/rxu_pkg.sv
/*
  Shared constants and the state type of the receive upper-bits port.
  Assumes a 32-bit AXI4-Lite register bus and a 12-bit receive character.
*/
package rxu_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int STRB_W = 4;
  localparam int CHAR_W = 12;
  localparam int DEC_W  = 10;
  localparam int SAR_W  = 10;
  localparam int CTRL_W = 3;
  localparam int EV_W   = 3;

  // ==========================================================================
  // Register map, byte addresses
  // ==========================================================================
  localparam logic [AXI_AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STAT  = 8'h04;
  localparam logic [AXI_AW-1:0] REG_MASK  = 8'h08;
  localparam logic [AXI_AW-1:0] REG_SADDR = 8'h0c;

  // Control fields and reset: decoder on, 8-bit width, self-test off.
  localparam int               CTRL_BYP_N = 0;
  localparam int               CTRL_WID8  = 1;
  localparam int               CTRL_BST_N = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h7;

  // Status and mask fields.
  localparam int EV_VIOL = 0;
  localparam int EV_MISM = 1;
  localparam int EV_SADR = 2;

  // Serial address register fields.
  localparam int SADDR_UNI = 10;
  localparam int BYTE_W    = 8;

  // ==========================================================================
  // Pin positions on the receive character bus
  // ==========================================================================
  localparam int PIN_B8   = 8;
  localparam int PIN_B9   = 9;
  localparam int PIN_VIOL = 10;
  localparam int PIN_SOC  = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [AXI_DW-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              aw_rdy;
    logic              w_rdy;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0]   stat;
    logic [EV_W-1:0]   mask;
    logic              irq;
    logic [SAR_W-1:0]  sar;
    logic              sar_uni;
    logic [CHAR_W-1:0] bus;
    logic [CHAR_W-1:0] bus_oe;
    logic              sc;
    logic              sc_oe;
  } rxu_state_t;

endpackage

//--- core/rxu_char_map.sv
/*
  Maps the received character onto the 12-bit bus for a normal read.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module rxu_char_map
  import rxu_pkg::*;
(
  input  wire logic              i_bypass_n,
  input  wire logic              i_width8,
  input  wire logic              i_selftest_n,
  input  wire logic [CHAR_W-1:0] i_raw,
  input  wire logic [DEC_W-1:0]  i_dec,
  input  wire logic              i_special,
  input  wire logic              i_violation,
  input  wire logic              i_cell_start,
  input  wire logic              i_mismatch,
  output logic      [CHAR_W-1:0] o_bus,
  output logic                   o_special
);

  // ==========================================================================
  // Bus mapping
  // ==========================================================================
  always_comb begin
    o_bus     = '0;
    o_special = 1'b0;
    if (!i_bypass_n) begin
      o_bus[PIN_B9:0] = i_raw[PIN_B9:0];
      // The upper two bits stay low with the short raw character.
      if (!i_width8) begin
        o_bus[PIN_SOC:PIN_VIOL] = i_raw[PIN_SOC:PIN_VIOL];
      end
    end else begin
      o_bus[PIN_B8-1:0] = i_dec[PIN_B8-1:0];
      // In 8-bit width the top decoded bits carry nothing and read low.
      if (!i_width8) begin
        o_bus[PIN_B9:PIN_B8] = i_dec[PIN_B9:PIN_B8];
      end
      o_bus[PIN_VIOL] = i_selftest_n ? i_violation : i_mismatch;
      o_bus[PIN_SOC]  = i_cell_start;
      o_special       = i_special;
    end
  end

endmodule

//--- core/rxu_port.sv
/*
  Receive-side parallel port, upper bits: maps bits 8 to 11 and the flags,
  turns the bus around for serial address register accesses, and holds
  control, status, mask and address registers behind AXI4-Lite.
  Assumes the host works synchronously to i_ref_clk and that a decoder and
  special-character table outside supply the character and its flags.
*/
// Our own choices: the address map and the AXI4-Lite register port.
// How it works
// - Bypass: raw ninth bit on bit 8.
// - Decoder, 10-bit: decoded tenth bit on bit 9.
// - Decoder, 8-bit: bit 9 carries nothing.
// - Bypass: raw tenth bit on bit 9.
// - Bypass 10-bit: raw eleventh bit on bit 10.
// - Bypass 8-bit: bit 10 driven low.
// - Normal read: violation pin output, joint flag code.
// - Self-test on: violation pin shows mismatches.
// - Address access, pin low: host writes address.
// - Address access, pin high: device drives address.
// - Start-of-cell output on bit 11, joint code.
// - Pins change or sample at clock edge.
`timescale 1ns/1ps
module rxu_port
  import rxu_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  // AXI4-Lite slave.
  input  wire logic [AXI_AW-1:0] i_axi_awaddr,
  input  wire logic [2:0]        i_axi_awprot,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [AXI_DW-1:0] i_axi_wdata,
  input  wire logic [STRB_W-1:0] i_axi_wstrb,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  output logic      [1:0]        o_axi_bresp,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  input  wire logic [AXI_AW-1:0] i_axi_araddr,
  input  wire logic [2:0]        i_axi_arprot,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  output logic      [AXI_DW-1:0] o_axi_rdata,
  output logic      [1:0]        o_axi_rresp,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  output logic                   o_irq,
  // Host pins.
  input  wire logic              i_receive_select,
  input  wire logic              i_sar_access,
  input  wire logic [CHAR_W-1:0] i_rx_char_bus,
  output logic      [CHAR_W-1:0] o_rx_char_bus,
  output logic      [CHAR_W-1:0] o_rx_char_bus_oe,
  input  wire logic              i_rx_special_char_flag,
  output logic                   o_rx_special_char_flag,
  output logic                   o_rx_special_char_flag_oe,
  // Receive path inside the device.
  input  wire logic [CHAR_W-1:0] i_raw_char,
  input  wire logic [DEC_W-1:0]  i_dec_char,
  input  wire logic              i_dec_special,
  input  wire logic              i_dec_violation,
  input  wire logic              i_dec_cell_start,
  input  wire logic              i_selftest_mismatch
);

  // ==========================================================================
  // State and bus qualifiers
  // ==========================================================================
  rxu_state_t        st;
  rxu_state_t        nx;
  logic [CHAR_W-1:0] map_bus;
  logic              map_sc;
  logic              norm_rd;
  logic              sar_wr;
  logic              sar_rd;
  logic              bypass_n;
  logic              width8;
  logic              selftest_n;
  logic              rd_clr;
  logic [EV_W-1:0]   ev;

  assign bypass_n   = st.ctrl[CTRL_BYP_N];
  assign width8     = st.ctrl[CTRL_WID8];
  assign selftest_n = st.ctrl[CTRL_BST_N];
  // A bus cycle only exists while receive select is high.
  assign norm_rd = i_receive_select && !i_sar_access;
  assign sar_wr  = i_receive_select && i_sar_access && !i_rx_char_bus[PIN_VIOL];
  assign sar_rd  = i_receive_select && i_sar_access && i_rx_char_bus[PIN_VIOL];

  rxu_char_map u_map (
    .i_bypass_n   (bypass_n),
    .i_width8     (width8),
    .i_selftest_n (selftest_n),
    .i_raw        (i_raw_char),
    .i_dec        (i_dec_char),
    .i_special    (i_dec_special),
    .i_violation  (i_dec_violation),
    .i_cell_start (i_dec_cell_start),
    .i_mismatch   (i_selftest_mismatch),
    .o_bus        (map_bus),
    .o_special    (map_sc)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nx     = st;
    ev     = '0;
    rd_clr = 1'b0;

    // Write address and data are taken independently, in either order.
    if (i_axi_awvalid && st.aw_rdy) begin
      nx.aw_full = 1'b1;
      nx.aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && st.w_rdy) begin
      nx.w_full = 1'b1;
      nx.w_data = i_axi_wdata;
      nx.w_strb = i_axi_wstrb;
    end
    if (i_axi_bready && st.bvalid) begin
      nx.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      nx.aw_full = 1'b0;
      nx.w_full  = 1'b0;
      nx.bvalid  = 1'b1;
      nx.bresp   = RESP_OKAY;
      unique case (st.aw_addr)
        REG_CTRL: begin
          if (st.w_strb[0]) begin
            nx.ctrl = st.w_data[CTRL_W-1:0];
          end
        end
        REG_MASK: begin
          if (st.w_strb[0]) begin
            nx.mask = st.w_data[EV_W-1:0];
          end
        end
        REG_STAT: begin
          // Status clears only by reading it; writes are accepted and dropped.
          nx.bresp = RESP_OKAY;
        end
        REG_SADDR: begin
          if (st.w_strb[0]) begin
            nx.sar[BYTE_W-1:0] = st.w_data[BYTE_W-1:0];
          end
          if (st.w_strb[1]) begin
            nx.sar[SAR_W-1:BYTE_W] = st.w_data[SAR_W-1:BYTE_W];
            nx.sar_uni             = st.w_data[SADDR_UNI];
          end
        end
        default: begin
          nx.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel: one read at a time, answered on the next edge.
    if (i_axi_rready && st.rvalid) begin
      nx.rvalid = 1'b0;
    end
    if (i_axi_arvalid && st.ar_rdy) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OKAY;
      nx.rdata  = '0;
      unique case (i_axi_araddr)
        REG_CTRL: begin
          nx.rdata[CTRL_W-1:0] = st.ctrl;
        end
        REG_STAT: begin
          nx.rdata[EV_W-1:0] = st.stat;
          rd_clr             = 1'b1;
        end
        REG_MASK: begin
          nx.rdata[EV_W-1:0] = st.mask;
        end
        REG_SADDR: begin
          nx.rdata[SADDR_UNI:0] = {st.sar_uni, st.sar};
        end
        default: begin
          nx.rresp = RESP_SLVERR;
        end
      endcase
    end
    nx.aw_rdy = !nx.aw_full && !nx.bvalid;
    nx.w_rdy  = !nx.w_full && !nx.bvalid;
    nx.ar_rdy = !nx.rvalid;

    // Pins are released by default so the bus floats between accesses.
    nx.bus    = '0;
    nx.bus_oe = '0;
    nx.sc     = 1'b0;
    nx.sc_oe  = 1'b0;
    if (norm_rd) begin
      nx.bus    = map_bus;
      nx.bus_oe = '1;
      nx.sc     = map_sc;
      nx.sc_oe  = 1'b1;
      ev[EV_VIOL] = bypass_n && selftest_n && i_dec_violation;
      ev[EV_MISM] = bypass_n && !selftest_n && i_selftest_mismatch;
    end else if (sar_wr) begin
      // A pin write lands after any bus write in the same cycle and wins.
      nx.sar      = i_rx_char_bus[SAR_W-1:0];
      nx.sar_uni  = i_rx_special_char_flag;
      ev[EV_SADR] = 1'b1;
    end else if (sar_rd) begin
      // Direction follows the host's level one edge late, so both drive for one edge if the host drives straight after a read.
      nx.bus[SAR_W-1:0]    = st.sar;
      nx.bus_oe[SAR_W-1:0] = '1;
      nx.sc                = st.sar_uni;
      nx.sc_oe             = 1'b1;
    end

    // A new event in the clearing cycle survives the clear.
    nx.stat = (rd_clr ? '0 : st.stat) | ev;
    nx.irq  = |(nx.stat & nx.mask);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st <= '{ctrl: CTRL_RST, aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};
    end else begin
      st <= nx;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_axi_awready             = st.aw_rdy;
  assign o_axi_wready              = st.w_rdy;
  assign o_axi_bvalid              = st.bvalid;
  assign o_axi_bresp               = st.bresp;
  assign o_axi_arready             = st.ar_rdy;
  assign o_axi_rvalid              = st.rvalid;
  assign o_axi_rdata               = st.rdata;
  assign o_axi_rresp               = st.rresp;
  assign o_irq                     = st.irq;
  assign o_rx_char_bus             = st.bus;
  assign o_rx_char_bus_oe          = st.bus_oe;
  assign o_rx_special_char_flag    = st.sc;
  assign o_rx_special_char_flag_oe = st.sc_oe;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_norm(logic byp_n, logic w8);
    norm_rd && (bypass_n == byp_n) && (width8 == w8);
  endsequence

  sequence s_both_taken;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
  endsequence

  sequence s_resp_out;
    ##[1:2] o_axi_bvalid;
  endsequence

  a_byp_bit8: assert property (norm_rd && !bypass_n |=>
      o_rx_char_bus[PIN_B8] == $past(i_raw_char[PIN_B8]) && o_rx_char_bus_oe[PIN_B8])
    else $error("bit 8 does not carry raw bit in bypass");

  a_dec_bit9: assert property (s_norm(1'b1, 1'b0) |=>
      o_rx_char_bus[PIN_B9] == $past(i_dec_char[PIN_B9]))
    else $error("bit 9 does not carry decoded top bit");

  a_dec8_bit9: assert property (s_norm(1'b1, 1'b1) |=> !o_rx_char_bus[PIN_B9])
    else $error("bit 9 not idle in decoded 8-bit width");

  a_byp_bit9: assert property (norm_rd && !bypass_n |=>
      o_rx_char_bus[PIN_B9] == $past(i_raw_char[PIN_B9]))
    else $error("bit 9 does not carry raw bit in bypass");

  a_byp_bit10: assert property (s_norm(1'b0, 1'b0) |=>
      o_rx_char_bus[PIN_VIOL] == $past(i_raw_char[PIN_VIOL]))
    else $error("bit 10 does not carry raw eleventh bit");

  a_byp8_low: assert property (s_norm(1'b0, 1'b1) |=>
      !o_rx_char_bus[PIN_VIOL] && !o_rx_char_bus[PIN_SOC] && o_rx_char_bus_oe[PIN_VIOL])
    else $error("bit 10 not driven low in short bypass");

  a_viol_flag: assert property (norm_rd && bypass_n && selftest_n |=>
      o_rx_char_bus[PIN_VIOL] == $past(i_dec_violation) && o_rx_special_char_flag_oe
      && o_rx_special_char_flag == $past(i_dec_special))
    else $error("violation or special flag wrong on normal read");

  a_selftest_rep: assert property (norm_rd && bypass_n && !selftest_n |=>
      o_rx_char_bus[PIN_VIOL] == $past(i_selftest_mismatch))
    else $error("self-test mismatch not on violation pin");

  a_sar_write: assert property (sar_wr |=>
      st.sar == $past(i_rx_char_bus[SAR_W-1:0]) && st.sar_uni == $past(i_rx_special_char_flag)
      && o_rx_char_bus_oe == '0 && !o_rx_special_char_flag_oe)
    else $error("address write not taken or pins still driven");

  a_sar_read: assert property (sar_rd |=>
      o_rx_char_bus[SAR_W-1:0] == $past(st.sar) && (&o_rx_char_bus_oe[SAR_W-1:0])
      && !o_rx_char_bus_oe[PIN_VIOL] && o_rx_special_char_flag == $past(st.sar_uni))
    else $error("address read not driven on bus");

  a_cell_start: assert property (norm_rd && bypass_n |=>
      o_rx_char_bus[PIN_SOC] == $past(i_dec_cell_start) && o_rx_char_bus_oe[PIN_SOC])
    else $error("start of cell flag wrong");

  a_idle_float: assert property (!i_receive_select |=> o_rx_char_bus_oe == '0)
    else $error("bus driven without receive select");

  a_write_resp: assert property (s_both_taken |-> s_resp_out)
    else $error("write response late");

  a_irq_level: assert property (o_irq == (|(st.stat & st.mask)))
    else $error("interrupt without a status bit");

endmodule

//--- tb/rxu_host_model.sv
/*
  Host system model for the receive upper-bits port pins.
  Assumes the bench sets i_cmd just after a rising edge: 0 idle, 1 read, 2 address write, 3 address read.
*/
`timescale 1ns/1ps
module rxu_host_model
  import rxu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [1:0]        i_cmd,
  input  wire logic [SAR_W-1:0]  i_addr,
  input  wire logic              i_unicast,
  input  wire logic [CHAR_W-1:0] i_dev_bus,
  input  wire logic [CHAR_W-1:0] i_dev_oe,
  input  wire logic              i_dev_flag,
  input  wire logic              i_dev_flag_oe,
  output logic                   o_select,
  output logic                   o_access,
  output logic      [CHAR_W-1:0] o_bus,
  output logic                   o_flag
);
  // ==========================================================================
  // Wire resolution
  // ==========================================================================
  // Released lines other than bit 10, which reads high, carry a shifting pattern so a stale value is never mistaken for data.
  logic [CHAR_W-1:0] filler = 12'ha5c;
  logic [CHAR_W-1:0] host_val;
  logic [CHAR_W-1:0] host_oe;

  always_ff @(posedge i_clk) filler <= {filler[10:0], ~filler[11]};

  always_comb begin
    o_select = (i_cmd != 2'h0);
    o_access = i_cmd[1];
    host_val = {1'b0, i_cmd[0], i_addr};
    host_oe  = (i_cmd == 2'h2) ? 12'h7ff : (i_cmd == 2'h3) ? 12'h400 : 12'h000;
    for (int b = 0; b < CHAR_W; b++) begin
      if (i_dev_oe[b]) o_bus[b] = i_dev_bus[b];
      else if (host_oe[b]) o_bus[b] = host_val[b];
      else o_bus[b] = (b == PIN_VIOL) ? 1'b1 : filler[b];
    end
    o_flag = i_dev_flag_oe ? i_dev_flag : (i_cmd == 2'h2) ? i_unicast : filler[0];
  end
endmodule

//--- tb/rxu_port_tb_top.sv
/*
  Self-checking bench of the receive upper-bits port: AXI4-Lite master tasks, host pin model, random reads.
  Assumes pin outputs follow one cycle after sampling and the registers sit behind AXI4-Lite.
*/
`timescale 1ns/1ps
module rxu_port_tb_top
  import rxu_pkg::*;
;
  logic              clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq, sel, acc, flag_in, dflag, dflag_oe;
  logic              uni, special, viol, cstart, mism;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata, d;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp, r, cmd;
  logic [CHAR_W-1:0] bus_in, dbus, dbus_oe, raw;
  logic [DEC_W-1:0]  dec;
  logic [SAR_W-1:0]  sadr;
  int                fails, n_tests;

  rxu_port rxu_port_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid),
    .i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arprot(3'h0), .i_axi_arvalid(arvalid),
    .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_irq(irq), .i_receive_select(sel), .i_sar_access(acc),
    .i_rx_char_bus(bus_in), .o_rx_char_bus(dbus), .o_rx_char_bus_oe(dbus_oe),
    .i_rx_special_char_flag(flag_in), .o_rx_special_char_flag(dflag),
    .o_rx_special_char_flag_oe(dflag_oe), .i_raw_char(raw), .i_dec_char(dec), .i_dec_special(special),
    .i_dec_violation(viol), .i_dec_cell_start(cstart), .i_selftest_mismatch(mism));

  rxu_host_model rxu_host_model_i (.i_clk(clk), .i_cmd(cmd), .i_addr(sadr), .i_unicast(uni),
    .i_dev_bus(dbus), .i_dev_oe(dbus_oe), .i_dev_flag(dflag), .i_dev_flag_oe(dflag_oe),
    .o_select(sel), .o_access(acc), .o_bus(bus_in), .o_flag(flag_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    rs = bvalid ? bresp : 2'h3;
    chk("write answer", 32'h1, 32'(bvalid));
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    dt = rdata;
    rs = rvalid ? rresp : 2'h3;
    chk("read answer", 32'h1, 32'(rvalid));
    rready <= 1'b0;
  endtask

  // Expected {flag, bus} of a normal read for the given control setting.
  function automatic logic [12:0] exp_map(input logic [2:0] c, input logic [11:0] rw, input logic [9:0] dc,
                                          input logic sp, input logic vi, input logic cs, input logic mm);
    if (!c[CTRL_BYP_N]) return {1'b0, c[CTRL_WID8] ? 2'b00 : rw[11:10], rw[9:0]};
    return {sp, cs, c[CTRL_BST_N] ? vi : mm, c[CTRL_WID8] ? 2'b00 : dc[9:8], dc[7:0]};
  endfunction

  task automatic pins(input logic [1:0] c, input logic [9:0] a, input logic u);
    @(posedge clk);
    cmd <= c; sadr <= a; uni <= u;
    raw <= 12'($urandom); dec <= 10'($urandom);
    {special, viol, cstart, mism} <= (c == 2'h1) ? 4'($urandom) : 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end

  initial begin
    logic [12:0] e;
    void'($urandom(56));
    {awvalid, wvalid, bready, arvalid, rready, uni, special, viol, cstart, mism} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; cmd = 2'h0; sadr = '0; raw = '0; dec = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axr(REG_CTRL, d, r);
    chk("ctrl reset", 32'(CTRL_RST), d);
    chk("read resp", 32'(RESP_OKAY), 32'(r));
    chk("oe reset", 32'h0, 32'(dbus_oe));
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      axw(REG_CTRL, 32'(m), r);
      chk("ctrl write resp", 32'(RESP_OKAY), 32'(r));
      repeat (8) begin
        pins(2'h1, 10'h0, 1'b0);
        e = exp_map(3'(m), raw, dec, special, viol, cstart, mism);
        chk("bus", 32'(e[11:0]), 32'(dbus));
        chk("bus oe", 32'hfff, 32'(dbus_oe));
        chk("flag", 32'(e[12]), 32'(dflag));
      end
      // The inputs stay put, so the second read shows only the events of this setting.
      axr(REG_STAT, d, r);
      axr(REG_STAT, d, r);
      chk("stat events", 32'({m[CTRL_BYP_N] & ~m[CTRL_BST_N] & mism, m[CTRL_BYP_N] & m[CTRL_BST_N] & viol}), d);
    end
    // The device still drives the bus one edge after a read, so the host idles before an access.
    pins(2'h0, 10'h0, 1'b0);
    $display("test normal reads done");
    for (int i = 0; i < 2; i++) begin
      axw(REG_MASK, 32'h0, r);
      axr(REG_STAT, d, r);
      sadr = (i == 0) ? 10'h3ff : 10'($urandom);
      pins(2'h2, sadr, i[0]);
      chk("write oe", 32'h0, 32'({dflag_oe, dbus_oe}));
      pins(2'h0, sadr, i[0]);
      chk("idle oe", 32'h0, 32'({dflag_oe, dbus_oe}));
      chk("irq masked", 32'h0, 32'(irq));
      pins(2'h3, sadr, i[0]);
      chk("addr bus", 32'(sadr), 32'(dbus[9:0]));
      chk("addr oe", 32'h3ff, 32'(dbus_oe));
      chk("unicast", 32'({1'b1, i[0]}), 32'({dflag_oe, dflag}));
      pins(2'h0, sadr, i[0]);
      axr(REG_SADDR, d, r);
      chk("addr reg", 32'({i[0], sadr}), d);
      axw(REG_MASK, 32'h4, r);
      repeat (2) @(posedge clk);
      chk("irq set", 32'h1, 32'(irq));
      axr(REG_STAT, d, r);
      chk("stat addr", 32'h4, d & 32'h4);
      repeat (2) @(posedge clk);
      chk("irq clear", 32'h0, 32'(irq));
    end
    $display("test address access done");
    axr(8'h10, d, r);
    chk("bad read resp", 32'(RESP_SLVERR), 32'(r));
    chk("bad read data", 32'h0, d);
    axw(8'h14, 32'h1, r);
    chk("bad write resp", 32'(RESP_SLVERR), 32'(r));
    axw(REG_SADDR, 32'h4a5, r);
    chk("addr write resp", 32'(RESP_OKAY), 32'(r));
    axr(REG_SADDR, d, r);
    chk("addr reg bus write", 32'h4a5, d);
    $display("test unmapped done");
    end_of_test;
  end
endmodule
